//--- hw/fbsm_top.sv
// Fieldbus slave communication state machine with the drive control state machine.
// How it works
// - Four states: init, preop, safeop, op.
// - Upward steps go one level at a time.
// - Downward requests may skip levels directly.
// - Init allows only controller register access.
// - Preop serves mailbox SDO, no process data.
// - Safeop sends inputs, ignores outputs, keeps SDO.
// - Op acts on both received and sent PDOs.
// - Op still serves mailbox SDO requests.
// - PDOs cyclic; SDOs aperiodic through mailbox.
// - One remappable and six fixed PDOs each way.
// - Only the CAN-over-fieldbus protocol is accepted.
// - Eight motion profile modes are accepted.
// - Separate drive control state machine is kept.
`timescale 1ns/10ps
`default_nettype none
module fbsm_top
(
   // Clock and reset.
   input  wire logic       ref_clk,
   input  wire logic       reset,
   // State requests from the master.
   input  wire logic       state_req_valid,
   input  wire logic [1:0] state_req,
   input  wire logic       err_ack,
   input  wire logic [1:0] proto_sel,
   // Mailbox and cyclic traffic strobes.
   input  wire logic       sdo_req,
   input  wire logic       pdo_cycle,
   input  wire logic       rx_pdo_valid,
   // PDO and mode selection.
   input  wire logic [2:0] rx_pdo_sel,
   input  wire logic [2:0] tx_pdo_sel,
   input  wire logic [3:0] mode_sel,
   input  wire logic       mode_wr,
   // Drive control commands.
   input  wire logic       cmd_shutdown,
   input  wire logic       cmd_switch_on,
   input  wire logic       cmd_enable,
   input  wire logic       cmd_disable,
   input  wire logic       cmd_quick_stop,
   input  wire logic       cmd_fault_reset,
   input  wire logic       fault_in,
   input  wire logic       fault_done,
   // Status outputs.
   output logic [3:0]      comm_state,
   output logic            trans_err,
   output logic            reg_access_en,
   output logic            sdo_en,
   output logic            sdo_resp,
   output logic            tx_pdo_en,
   output logic            rx_pdo_en,
   output logic            tx_pdo_strobe,
   output logic            rx_pdo_apply,
   output logic [2:0]      rx_pdo_act,
   output logic [2:0]      tx_pdo_act,
   output logic [3:0]      mode_act,
   output logic            mode_err,
   output logic [8:0]      ctrl_state
);

   typedef struct packed {
      fbsm_pkg::fbsm_comm_e comm;
      fbsm_pkg::fbsm_ctrl_e ctrl;
      logic                 trans_err;
      logic                 sdo_resp;
      logic                 tx_strobe;
      logic                 rx_apply;
      logic [2:0]           rx_act;
      logic [2:0]           tx_act;
      logic [3:0]           mode;
      logic                 mode_err;
      logic                 acc_en;
      logic                 sdo_en;
      logic                 tx_en;
      logic                 rx_en;
   } fbsm_state_s;

   fbsm_state_s st_reg;
   fbsm_state_s st_next;
   logic        skip_up;
   logic        proto_ok;
   logic        mode_ok;

   // Next-state logic for both state machines and the data-path flags.
   always_comb
   begin
      st_next = st_reg;
      skip_up = 1'b0;
      proto_ok = (proto_sel == fbsm_pkg::PROTO_COE);
      mode_ok = 1'b0;
      st_next.sdo_resp = 1'b0;
      st_next.tx_strobe = 1'b0;
      st_next.rx_apply = 1'b0;
      if (err_ack)
      begin
         st_next.trans_err = 1'b0;
      end
      // Communication state transitions.
      if (state_req_valid)
      begin
         unique case (st_reg.comm)
            fbsm_pkg::ST_INIT:
            begin
               if (state_req == fbsm_pkg::REQ_PREOP)
               begin
                  st_next.comm = fbsm_pkg::ST_PREOP;
               end
               else if (state_req != fbsm_pkg::REQ_INIT)
               begin
                  skip_up = 1'b1;
               end
            end
            fbsm_pkg::ST_PREOP:
            begin
               if (state_req == fbsm_pkg::REQ_SAFEOP)
               begin
                  st_next.comm = fbsm_pkg::ST_SAFEOP;
               end
               else if (state_req == fbsm_pkg::REQ_INIT)
               begin
                  st_next.comm = fbsm_pkg::ST_INIT;
               end
               else if (state_req == fbsm_pkg::REQ_OP)
               begin
                  skip_up = 1'b1;
               end
            end
            fbsm_pkg::ST_SAFEOP:
            begin
               if (state_req == fbsm_pkg::REQ_OP)
               begin
                  st_next.comm = fbsm_pkg::ST_OP;
               end
               else if (state_req == fbsm_pkg::REQ_PREOP)
               begin
                  st_next.comm = fbsm_pkg::ST_PREOP;
               end
               else if (state_req == fbsm_pkg::REQ_INIT)
               begin
                  st_next.comm = fbsm_pkg::ST_INIT;
               end
            end
            fbsm_pkg::ST_OP:
            begin
               // Any lower target is taken in one step.
               unique case (state_req)
                  fbsm_pkg::REQ_INIT:   st_next.comm = fbsm_pkg::ST_INIT;
                  fbsm_pkg::REQ_PREOP:  st_next.comm = fbsm_pkg::ST_PREOP;
                  fbsm_pkg::REQ_SAFEOP: st_next.comm = fbsm_pkg::ST_SAFEOP;
                  fbsm_pkg::REQ_OP:     st_next.comm = fbsm_pkg::ST_OP;
               endcase
            end
            default:
            begin
               st_next.comm = fbsm_pkg::ST_INIT;
            end
         endcase
      end
      // A skipping upward request holds the state; the set wins over acknowledge.
      if (skip_up)
      begin
         st_next.trans_err = 1'b1;
      end
      // Mailbox SDO is answered outside init only.
      if (sdo_req && proto_ok && st_reg.comm != fbsm_pkg::ST_INIT)
      begin
         st_next.sdo_resp = 1'b1;
      end
      // Cyclic process data: inputs from safeop, outputs only in op.
      if (pdo_cycle && proto_ok)
      begin
         if (st_reg.comm == fbsm_pkg::ST_SAFEOP || st_reg.comm == fbsm_pkg::ST_OP)
         begin
            st_next.tx_strobe = 1'b1;
         end
         if (st_reg.comm == fbsm_pkg::ST_OP && rx_pdo_valid)
         begin
            st_next.rx_apply = 1'b1;
         end
      end
      // PDO choice is fixed before process data starts.
      if (st_reg.comm == fbsm_pkg::ST_PREOP)
      begin
         if (rx_pdo_sel <= fbsm_pkg::PDO_FIXED_MAX)
         begin
            st_next.rx_act = rx_pdo_sel;
         end
         if (tx_pdo_sel <= fbsm_pkg::PDO_FIXED_MAX)
         begin
            st_next.tx_act = tx_pdo_sel;
         end
      end
      // Mode selection accepts the eight supported profile modes.
      unique case (mode_sel)
         fbsm_pkg::MODE_PP, fbsm_pkg::MODE_PV, fbsm_pkg::MODE_PT,
         fbsm_pkg::MODE_HM, fbsm_pkg::MODE_IP, fbsm_pkg::MODE_CSP,
         fbsm_pkg::MODE_CSV, fbsm_pkg::MODE_CST: mode_ok = 1'b1;
         default: mode_ok = 1'b0;
      endcase
      if (mode_wr && st_reg.comm != fbsm_pkg::ST_INIT)
      begin
         st_next.mode_err = !mode_ok;
         if (mode_ok)
         begin
            st_next.mode = mode_sel;
         end
      end
      // Drive control state machine, independent of the link state.
      unique case (st_reg.ctrl)
         fbsm_pkg::CS_START:     st_next.ctrl = fbsm_pkg::CS_NOT_READY;
         fbsm_pkg::CS_NOT_READY: st_next.ctrl = fbsm_pkg::CS_SW_DIS;
         fbsm_pkg::CS_SW_DIS:
            if (cmd_shutdown) st_next.ctrl = fbsm_pkg::CS_READY;
         fbsm_pkg::CS_READY:
            if (cmd_switch_on) st_next.ctrl = fbsm_pkg::CS_SW_ON;
            else if (cmd_disable || cmd_quick_stop) st_next.ctrl = fbsm_pkg::CS_SW_DIS;
         fbsm_pkg::CS_SW_ON:
            if (cmd_enable) st_next.ctrl = fbsm_pkg::CS_OP_EN;
            else if (cmd_shutdown) st_next.ctrl = fbsm_pkg::CS_READY;
            else if (cmd_disable || cmd_quick_stop) st_next.ctrl = fbsm_pkg::CS_SW_DIS;
         fbsm_pkg::CS_OP_EN:
            if (cmd_quick_stop) st_next.ctrl = fbsm_pkg::CS_QSTOP;
            else if (cmd_disable) st_next.ctrl = fbsm_pkg::CS_SW_DIS;
            else if (cmd_shutdown) st_next.ctrl = fbsm_pkg::CS_READY;
         fbsm_pkg::CS_QSTOP:
            if (cmd_disable) st_next.ctrl = fbsm_pkg::CS_SW_DIS;
         fbsm_pkg::CS_FLT_REACT:
            if (fault_done) st_next.ctrl = fbsm_pkg::CS_FAULT;
         fbsm_pkg::CS_FAULT:
            if (cmd_fault_reset && !fault_in) st_next.ctrl = fbsm_pkg::CS_SW_DIS;
         default: st_next.ctrl = fbsm_pkg::CS_START;
      endcase
      // A fault overrides every working state.
      if (fault_in && st_reg.ctrl != fbsm_pkg::CS_FAULT && st_reg.ctrl != fbsm_pkg::CS_START)
      begin
         st_next.ctrl = fbsm_pkg::CS_FLT_REACT;
      end
      // Service enables are registered from the state being entered, so they turn with it.
      st_next.acc_en = 1'b1;
      st_next.sdo_en = (st_next.comm != fbsm_pkg::ST_INIT);
      st_next.tx_en = st_next.comm[2] | st_next.comm[3];
      st_next.rx_en = st_next.comm[3];
   end

   // State register.
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         st_reg.comm <= fbsm_pkg::ST_INIT;
         st_reg.ctrl <= fbsm_pkg::CS_START;
         st_reg.trans_err <= 1'b0;
         st_reg.sdo_resp <= 1'b0;
         st_reg.tx_strobe <= 1'b0;
         st_reg.rx_apply <= 1'b0;
         st_reg.rx_act <= fbsm_pkg::PDO_RESET;
         st_reg.tx_act <= fbsm_pkg::PDO_RESET;
         st_reg.mode <= fbsm_pkg::MODE_RESET;
         st_reg.mode_err <= 1'b0;
         st_reg.acc_en <= 1'b0;
         st_reg.sdo_en <= 1'b0;
         st_reg.tx_en <= 1'b0;
         st_reg.rx_en <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state register.
   assign comm_state    = st_reg.comm;
   assign trans_err     = st_reg.trans_err;
   assign reg_access_en = st_reg.acc_en;
   assign sdo_en        = st_reg.sdo_en;
   assign tx_pdo_en     = st_reg.tx_en;
   assign rx_pdo_en     = st_reg.rx_en;
   assign sdo_resp      = st_reg.sdo_resp;
   assign tx_pdo_strobe = st_reg.tx_strobe;
   assign rx_pdo_apply  = st_reg.rx_apply;
   assign rx_pdo_act    = st_reg.rx_act;
   assign tx_pdo_act    = st_reg.tx_act;
   assign mode_act      = st_reg.mode;
   assign mode_err      = st_reg.mode_err;
   assign ctrl_state    = st_reg.ctrl;

endmodule
`default_nettype wire

//--- hw/fbsm_pkg.sv
// Package of constants and types for the fieldbus slave state machine.
`default_nettype none
package fbsm_pkg;
   // Communication states, one-hot.
   typedef enum logic [3:0] {
      ST_INIT   = 4'h1,
      ST_PREOP  = 4'h2,
      ST_SAFEOP = 4'h4,
      ST_OP     = 4'h8
   } fbsm_comm_e;

   // Drive control states, one-hot.
   typedef enum logic [8:0] {
      CS_START     = 9'h001,
      CS_NOT_READY = 9'h002,
      CS_SW_DIS    = 9'h004,
      CS_READY     = 9'h008,
      CS_SW_ON     = 9'h010,
      CS_OP_EN     = 9'h020,
      CS_QSTOP     = 9'h040,
      CS_FLT_REACT = 9'h080,
      CS_FAULT     = 9'h100
   } fbsm_ctrl_e;

   // Requested state codes on the request port.
   localparam logic [1:0] REQ_INIT   = 2'h0;
   localparam logic [1:0] REQ_PREOP  = 2'h1;
   localparam logic [1:0] REQ_SAFEOP = 2'h2;
   localparam logic [1:0] REQ_OP     = 2'h3;

   // Motion modes, as the mode-select code of the drive profile.
   localparam logic [3:0] MODE_PP  = 4'h1;
   localparam logic [3:0] MODE_PV  = 4'h3;
   localparam logic [3:0] MODE_PT  = 4'h4;
   localparam logic [3:0] MODE_HM  = 4'h6;
   localparam logic [3:0] MODE_IP  = 4'h7;
   localparam logic [3:0] MODE_CSP = 4'h8;
   localparam logic [3:0] MODE_CSV = 4'h9;
   localparam logic [3:0] MODE_CST = 4'hA;

   // PDO selection: index 0 is the remappable one, 1 to 6 fixed ones.
   localparam int         PDO_FIXED_COUNT = 6;
   localparam logic [2:0] PDO_REMAP_SEL   = 3'h0;
   localparam logic [2:0] PDO_FIXED_MAX   = 3'h6;

   // Application protocol codes; only the CAN-over-fieldbus one is served.
   localparam logic [1:0] PROTO_COE = 2'h0;

   // Reset values.
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [2:0] PDO_RESET  = 3'h0;
endpackage
`default_nettype wire

//--- test/fbsm_assertions.sv
// Port checker of the fieldbus slave state machine.
`timescale 1ns/10ps
`default_nettype none
module fbsm_assertions
(
   // Clock and reset.
   input wire logic       ref_clk,
   input wire logic       reset,
   // Master requests.
   input wire logic       state_req_valid,
   input wire logic [1:0] state_req,
   input wire logic [1:0] proto_sel,
   input wire logic       sdo_req,
   input wire logic       pdo_cycle,
   // Status.
   input wire logic [3:0] comm_state,
   input wire logic       trans_err,
   input wire logic       sdo_en,
   input wire logic       sdo_resp,
   input wire logic       tx_pdo_en,
   input wire logic       tx_pdo_strobe,
   input wire logic       rx_pdo_apply
);
   // State level from init 0 to op 3, and the served protocol.
   wire logic [2:0] lvl = {1'b0, comm_state[3] | comm_state[2], comm_state[3] | comm_state[1]};
   wire logic       coe = proto_sel == 2'h0;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Valid requests, split by direction.
   sequence s_up; state_req_valid && {1'b0, state_req} == lvl + 3'h1; endsequence
   sequence s_skip; state_req_valid && {1'b0, state_req} > lvl + 3'h1; endsequence
   sequence s_down; state_req_valid && {1'b0, state_req} < lvl; endsequence
   a_state_one_hot: assert property ($onehot(comm_state))
      else $error("state not one-hot");
   a_up_one_step: assert property (s_up |=> comm_state == 4'h1 << $past(state_req))
      else $error("upward step lost");
   a_skip_held: assert property (s_skip |=> comm_state == $past(comm_state) && trans_err)
      else $error("skip not refused");
   a_down_direct: assert property (s_down |=> comm_state == 4'h1 << $past(state_req))
      else $error("downward jump lost");
   a_init_quiet: assert property (comm_state == 4'h1 |-> !sdo_en && !tx_pdo_en ##1 !sdo_resp)
      else $error("traffic in init");
   a_preop_mailbox: assert property (comm_state == 4'h2 |-> sdo_en && !tx_pdo_en)
      else $error("preop services wrong");
   a_sdo_answer: assert property (sdo_req && sdo_en && coe |=> sdo_resp)
      else $error("mailbox request unanswered");
   a_safeop_inputs: assert property (comm_state == 4'h4 && pdo_cycle && coe |=>
      tx_pdo_strobe && !rx_pdo_apply) else $error("safeop process data wrong");
endmodule
bind fbsm_top fbsm_assertions chk_u (.*);
`default_nettype wire

//--- test/fbsm_master_model.sv
// Behavioural master station driving state requests and traffic strobes.
`timescale 1ns/10ps
`default_nettype none
module fbsm_master_model
(
   // Clock.
   input  wire logic      ref_clk,
   // Requests toward the slave, quiet at time zero.
   output var logic       state_req_valid,
   output var logic [1:0] state_req,
   output var logic       sdo_req,
   output var logic       pdo_cycle,
   output var logic       rx_pdo_valid
);
   // All requests start quiet.
   initial
   begin
      state_req_valid = 1'b0;
      state_req = 2'h0;
      sdo_req = 1'b0;
      pdo_cycle = 1'b0;
      rx_pdo_valid = 1'b0;
   end
   // One state request; station setup, mapping and sync setup are done beforehand.
   task automatic req(input logic [1:0] target);
      @(posedge ref_clk);
      #1;
      state_req_valid = 1'b1;
      state_req = target;
      @(posedge ref_clk);
      #1;
      state_req_valid = 1'b0;
      state_req = ~target; // A released code must not look like the last one.
   endtask
   // One mailbox request when mb is set, else one process data cycle.
   task automatic strobe(input logic mb);
      @(posedge ref_clk);
      #1;
      sdo_req = mb;
      pdo_cycle = !mb;
      @(posedge ref_clk);
      #1;
      sdo_req = 1'b0;
      pdo_cycle = 1'b0;
   endtask
   // Valid output data are sent before op is requested.
   task automatic outputs(input logic v);
      rx_pdo_valid = v;
   endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench of the fieldbus slave state machine.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   // Bench inputs, model requests and design answers.
   logic       ref_clk, reset, err_ack, mode_wr;
   logic [1:0] proto_sel, state_req;
   logic [2:0] rx_pdo_sel, tx_pdo_sel, rx_pdo_act, tx_pdo_act;
   logic [3:0] mode_sel, comm_state, mode_act;
   logic [7:0] cmd;
   logic [8:0] ctrl_state;
   logic       state_req_valid, sdo_req, pdo_cycle, rx_pdo_valid, trans_err, reg_access_en;
   logic       sdo_en, sdo_resp, tx_pdo_en, rx_pdo_en, tx_pdo_strobe, rx_pdo_apply, mode_err;
   int         errors = 0, n_checks = 0, cycles = 0;
   // Clock of 10 ns.
   always #5 ref_clk = ~ref_clk;
   fbsm_master_model master_u (.ref_clk(ref_clk), .state_req_valid(state_req_valid),
      .state_req(state_req), .sdo_req(sdo_req), .pdo_cycle(pdo_cycle),
      .rx_pdo_valid(rx_pdo_valid));
   fbsm_top dut_u (.ref_clk(ref_clk), .reset(reset), .state_req_valid(state_req_valid),
      .state_req(state_req), .err_ack(err_ack), .proto_sel(proto_sel), .sdo_req(sdo_req),
      .pdo_cycle(pdo_cycle), .rx_pdo_valid(rx_pdo_valid), .rx_pdo_sel(rx_pdo_sel),
      .tx_pdo_sel(tx_pdo_sel), .mode_sel(mode_sel), .mode_wr(mode_wr),
      .cmd_shutdown(cmd[0]), .cmd_switch_on(cmd[1]), .cmd_enable(cmd[2]),
      .cmd_disable(cmd[3]), .cmd_quick_stop(cmd[4]), .cmd_fault_reset(cmd[5]),
      .fault_in(cmd[6]), .fault_done(cmd[7]),
      .comm_state(comm_state), .trans_err(trans_err), .reg_access_en(reg_access_en),
      .sdo_en(sdo_en), .sdo_resp(sdo_resp), .tx_pdo_en(tx_pdo_en), .rx_pdo_en(rx_pdo_en),
      .tx_pdo_strobe(tx_pdo_strobe), .rx_pdo_apply(rx_pdo_apply), .rx_pdo_act(rx_pdo_act),
      .tx_pdo_act(tx_pdo_act), .mode_act(mode_act), .mode_err(mode_err),
      .ctrl_state(ctrl_state));
   // Compare and count.
   task automatic chk(input logic [8:0] got, exp);
      n_checks++;
      if (got !== exp) $display("unexpected at %0t: %h, expected %h", $time, got, exp);
      if (got !== exp) errors++;
   endtask
   // Wait n edges, then step just past the last one.
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Pulse helpers.
   task automatic ack;
      err_ack = 1'b1;
      tick(1);
      err_ack = 1'b0;
   endtask
   task automatic ctl(input int i, input logic [8:0] exp);
      tick(1);
      cmd = 8'h01 << i;
      tick(1);
      cmd = 8'h00;
      chk(ctrl_state, exp);
   endtask
   // Init state refuses the mailbox; drive control walks its states.
   task automatic t_init;
      chk({reg_access_en, comm_state}, 5'h11);
      master_u.strobe(1'b1);
      chk(sdo_resp, 1'h0);
      chk(ctrl_state, 9'h004);
      ctl(0, 9'h008);
      ctl(1, 9'h010);
      ctl(2, 9'h020);
      ctl(4, 9'h040);
      ctl(6, 9'h080);
      ctl(7, 9'h100);
      ctl(5, 9'h004);
      ctl(0, 9'h008);
      ctl(3, 9'h004);
      $display("test init done");
   endtask
   // Skipping requests are held and flagged until acknowledged.
   task automatic t_skip;
      master_u.req(2'h3);
      chk({trans_err, comm_state}, 5'h11);
      ack();
      master_u.req(2'h1);
      master_u.req(2'h3);
      chk({trans_err, comm_state}, 5'h12);
      ack();
      chk(trans_err, 1'h0);
      $display("test skip done");
   endtask
   // PDO selection and motion modes, set in preop.
   task automatic t_preop;
      logic [3:0] codes [9] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'h2};
      rx_pdo_sel = 3'h6;
      tx_pdo_sel = 3'h6;
      tick(2);
      rx_pdo_sel = 3'h7;
      tx_pdo_sel = 3'h0;
      tick(2);
      chk({rx_pdo_act, tx_pdo_act}, 6'h30);
      foreach (codes[i])
      begin
         mode_sel = codes[i];
         mode_wr = 1'b1;
         tick(1);
         mode_wr = 1'b0;
         chk({mode_err, mode_act}, (i < 8) ? {1'b0, codes[i]} : 5'h1A);
         tick(1);
      end
      $display("test preop done");
   endtask
   // Climb to op, then protocol block and direct downward jumps.
   task automatic t_climb;
      master_u.strobe(1'b1);
      chk(sdo_resp, 1'h1);
      master_u.strobe(1'b0);
      chk(tx_pdo_strobe, 1'h0);
      master_u.req(2'h2);
      master_u.outputs(1'b1);
      master_u.strobe(1'b0);
      chk({tx_pdo_strobe, rx_pdo_apply}, 2'h2);
      master_u.req(2'h3);
      master_u.strobe(1'b0);
      chk({comm_state, tx_pdo_en, rx_pdo_en, tx_pdo_strobe, rx_pdo_apply}, 8'h8F);
      master_u.strobe(1'b1);
      chk(sdo_resp, 1'h1);
      proto_sel = 2'h1;
      master_u.strobe(1'b0);
      chk(tx_pdo_strobe, 1'h0);
      proto_sel = 2'h0;
      master_u.req(2'h0);
      chk(comm_state, 4'h1);
      master_u.req(2'h1);
      master_u.req(2'h2);
      master_u.req(2'h0);
      chk({trans_err, comm_state}, 5'h01);
      mode_sel = 4'h1;
      mode_wr = 1'b1;
      tick(1);
      mode_wr = 1'b0;
      chk({mode_err, mode_act}, 5'h1A);
      $display("test climb done");
   endtask
   // Verdict.
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Cut a hung run short.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000) errors++;
      if (cycles == 2000) report_and_stop();
   end
   // Main sequence.
   initial
   begin
      ref_clk = 1'b0;
      reset = 1'b1;
      err_ack = 1'b0;
      mode_wr = 1'b0;
      proto_sel = 2'h0;
      rx_pdo_sel = 3'h0;
      tx_pdo_sel = 3'h0;
      mode_sel = 4'h0;
      cmd = 8'h00;
      tick(10);
      reset = 1'b0;
      tick(3);
      t_init();
      t_skip();
      t_preop();
      t_climb();
      report_and_stop();
   end
endmodule
`default_nettype wire
